// ===== hw/ccs_compare_set.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - equal count and compare value sets result
// - result stays set after match is gone
// - match acts at once, not by scan
// - interrupt target starts routine on equality
// - interrupt counter used elsewhere flags error
// - six-interrupt counter to interrupt mapping
// - one flag disables all counter interrupts
// - six flags disable interrupts one by one
// - Y0-Y3 at once, other outputs at scan end
// - relay targets updated at once on match
// - software pool over six flags error
// - software counter to interrupt mapping
// - two hardware groups of four comparators
// - hardware group over four flags error
// - hardware interrupts unique, A low, B high
// - counter membership of groups A and B
// - enabled C243 replaces C245 without error
// - software comparator fires on equal count
// - hardware fires at value plus or minus one
module ccs_compare_set (
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire ccs_pkg::ccs_variant_t         variant,
  input  wire logic [ccs_pkg::NUM_CNT-1:0]
                    [ccs_pkg::CNT_W-1:0]     counterValue,
  input  wire logic [ccs_pkg::NUM_CNT-1:0]   counterUp,
  input  wire logic                          grpAMainOn,
  input  wire logic [ccs_pkg::NUM_SLOT-1:0]  slotEnable,
  input  wire logic [ccs_pkg::NUM_SLOT-1:0]
                    [7:0]                    slotCounter,
  input  wire logic [ccs_pkg::NUM_SLOT-1:0]
                    [ccs_pkg::CNT_W-1:0]     slotValue,
  input  wire ccs_pkg::ccs_target_t
                    [ccs_pkg::NUM_SLOT-1:0]  slotTarget,
  input  wire logic [ccs_pkg::NUM_SLOT-1:0]
                    [ccs_pkg::IDX_W-1:0]     slotIndex,
  input  wire logic [ccs_pkg::NUM_CNT-1:0]   otherUseMask,
  input  wire logic [ccs_pkg::USE_W-1:0]     swResetUses,
  input  wire logic [ccs_pkg::USE_W-1:0]     grpAResetUses,
  input  wire logic [ccs_pkg::USE_W-1:0]     grpBResetUses,
  input  wire logic                          irqDisableAll,
  input  wire logic [ccs_pkg::NUM_DIS-1:0]   irqDisable,
  input  wire logic [ccs_pkg::NUM_SLOT-1:0]  resultClear,
  input  wire logic                          outClear,
  input  wire logic                          scanEnd,
  output logic      [ccs_pkg::NUM_SLOT-1:0]  resultBit,
  output logic      [3:0]                    fastOut,
  output logic      [7:0]                    scanOut,
  output logic      [7:0]                    relayOut,
  output logic      [ccs_pkg::NUM_IRQ-1:0]   irqReq,
  output logic      [ccs_pkg::ERR_W-1:0]     cfgError
);

  localparam int NSL = ccs_pkg::NUM_SLOT;
  localparam int NSW = ccs_pkg::NUM_SW;
  localparam int NGR = ccs_pkg::NUM_GRP;
  localparam int NIR = ccs_pkg::NUM_IRQ;

  // slot position decides the comparator kind and its group
  function automatic ccs_pkg::ccs_group_t slot_group(input int s);
    if (s < NSW) begin
      slot_group = ccs_pkg::GRP_NONE;
    end else if (s < NSW + NGR) begin
      slot_group = ccs_pkg::GRP_A;
    end else begin
      slot_group = ccs_pkg::GRP_B;
    end
  endfunction

  // counter number to counter port index, zero when out of range
  function automatic logic [4:0] cnt_index(input logic [7:0] num);
    logic [7:0] off;
    off = num - ccs_pkg::CNT_FIRST;
    if (num < ccs_pkg::CNT_FIRST) begin
      cnt_index = 5'h00;
    end else begin
      cnt_index = off[4:0];
    end
  endfunction

  logic [NSL-1:0][7:0]       srcNum;
  logic [NSL-1:0]            slotOk;
  logic [NSL-1:0]            hit;
  logic [NSL-1:0]            resultQ;
  logic [3:0]                fastOutQ;
  logic [7:0]                scanPendQ;
  logic [7:0]                scanOutQ;
  logic [7:0]                relayOutQ;
  logic [NIR-1:0]            irqReqQ;
  logic [ccs_pkg::ERR_W-1:0] cfgErrorQ;
  logic [ccs_pkg::ERR_W-1:0] cfgErrorD;
  logic [3:0]                setFast;
  logic [7:0]                setScan;
  logic [7:0]                setRelay;
  logic [NIR-1:0]            irqFire;
  logic [NIR-1:0]            irqMask;
  logic                      splitMode;

  assign splitMode = (variant == ccs_pkg::VAR_SW_HW);

  // source counter and selector check for every slot
  always_comb begin
    for (int i = 0; i < NSL; i++) begin
      srcNum[i] = slotCounter[i];
      if (slot_group(i) == ccs_pkg::GRP_A &&
          slotCounter[i] == ccs_pkg::CNT_A_ALIAS && grpAMainOn) begin
        srcNum[i] = ccs_pkg::CNT_A_MAIN;
      end
      if (slot_group(i) != ccs_pkg::GRP_NONE) begin
        // a hardware slot only takes counters of its own group
        slotOk[i] = (ccs_pkg::cnt_group(srcNum[i]) == slot_group(i));
      end else if (splitMode) begin
        slotOk[i] = (srcNum[i] >= ccs_pkg::CNT_FIRST) &&
                    (srcNum[i] <= ccs_pkg::CNT_SW_LAST);
      end else begin
        slotOk[i] = (srcNum[i] >= ccs_pkg::CNT_HS_FIRST);
      end
    end
  end

  // one comparator per slot: six software, four each in A and B
  ccs_slot_if slotIf[NSL] ();

  for (genvar g = 0; g < NSL; g++) begin : gSlot
    logic [4:0] idx;
    assign idx = slotOk[g] ? cnt_index(srcNum[g]) : 5'h00;
    assign slotIf[g].en     = slotEnable[g] & slotOk[g];
    assign slotIf[g].hwKind = (g >= NSW) && splitMode;
    assign slotIf[g].up     = counterUp[idx];
    assign slotIf[g].count  = counterValue[idx];
    assign slotIf[g].value  = slotValue[g];
    assign hit[g]           = slotIf[g].hit;

    ccs_comparator uCmp (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .slot    (slotIf[g])
    );
  end

  // configuration checks, recomputed every cycle
  always_comb begin
    logic [ccs_pkg::USE_W-1:0] swUse;
    logic [ccs_pkg::USE_W-1:0] aUse;
    logic [ccs_pkg::USE_W-1:0] bUse;
    logic [3:0]                want;
    cfgErrorD = '0;
    swUse     = swResetUses;
    aUse      = grpAResetUses;
    bUse      = grpBResetUses;
    want      = ccs_pkg::IRQ_NONE;
    for (int i = 0; i < NSL; i++) begin
      if (slotEnable[i]) begin
        if (!slotOk[i]) begin
          cfgErrorD[ccs_pkg::ERR_SEL] = 1'b1;
        end
        // count every set comparison against its shared pool
        unique case (slot_group(i))
          ccs_pkg::GRP_NONE: swUse = swUse + 5'h01;
          ccs_pkg::GRP_A:    aUse  = aUse + 5'h01;
          ccs_pkg::GRP_B:    bUse  = bUse + 5'h01;
          default:           swUse = swUse;
        endcase
        if (slotTarget[i] == ccs_pkg::TGT_IRQ) begin
          // fixed mapping unless a hardware slot in split mode
          if (slot_group(i) == ccs_pkg::GRP_NONE || !splitMode) begin
            want = splitMode ? ccs_pkg::sw_irq(srcNum[i])
                             : ccs_pkg::six_irq(srcNum[i]);
            if (want[3] || want[2:0] != slotIndex[i]) begin
              cfgErrorD[ccs_pkg::ERR_IRQMAP] = 1'b1;
            end
          end else if ((slot_group(i) == ccs_pkg::GRP_A) ==
                       slotIndex[i][2]) begin
            cfgErrorD[ccs_pkg::ERR_IRQMAP] = 1'b1;
          end
          if (slotOk[i] && otherUseMask[cnt_index(srcNum[i])]) begin
            cfgErrorD[ccs_pkg::ERR_SHARE] = 1'b1;
          end
          for (int j = 0; j < NSL; j++) begin
            if (j != i && slotEnable[j] && srcNum[j] == srcNum[i]) begin
              cfgErrorD[ccs_pkg::ERR_SHARE] = 1'b1;
            end
            if (j != i && splitMode && i >= NSW && j >= NSW &&
                slotEnable[j] && slotTarget[j] == ccs_pkg::TGT_IRQ &&
                slotIndex[j] == slotIndex[i]) begin
              cfgErrorD[ccs_pkg::ERR_IRQMAP] = 1'b1;
            end
          end
        end
      end
    end
    if (swUse > ccs_pkg::POOL_SW) begin
      cfgErrorD[ccs_pkg::ERR_SW_POOL] = 1'b1;
    end
    if (aUse > ccs_pkg::POOL_HW || bUse > ccs_pkg::POOL_HW) begin
      cfgErrorD[ccs_pkg::ERR_HW_POOL] = 1'b1;
    end
  end

  // route each equality event to the target its slot names
  always_comb begin
    setFast  = '0;
    setScan  = '0;
    setRelay = '0;
    irqFire  = '0;
    for (int i = 0; i < NSL; i++) begin
      if (hit[i]) begin
        unique case (slotTarget[i])
          ccs_pkg::TGT_FAST:  setFast[slotIndex[i][1:0]] = 1'b1;
          ccs_pkg::TGT_SCAN:  setScan[slotIndex[i]]      = 1'b1;
          ccs_pkg::TGT_RELAY: setRelay[slotIndex[i]]     = 1'b1;
          ccs_pkg::TGT_IRQ:   irqFire[slotIndex[i]]      = 1'b1;
          default:            setFast                    = setFast;
        endcase
      end
    end
  end

  // interrupt inhibit: one global flag, or one flag per interrupt
  always_comb begin
    if (variant == ccs_pkg::VAR_PER_DIS) begin
      irqMask = {2'h0, irqDisable};
    end else begin
      irqMask = {NIR{irqDisableAll}};
    end
  end

  // per-slot result latch; a hit in the clear cycle still sets it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      resultQ <= '0;
    end else begin
      resultQ <= hit | (resultQ & ~resultClear);
    end
  end

  // fast outputs and relays follow the event on the next edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fastOutQ  <= '0;
      relayOutQ <= '0;
    end else begin
      fastOutQ  <= setFast | (fastOutQ & ~{4{outClear}});
      relayOutQ <= setRelay | (relayOutQ & ~{8{outClear}});
    end
  end

  // slow outputs gather events and only move at the scan refresh
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scanPendQ <= '0;
      scanOutQ  <= '0;
    end else begin
      scanPendQ <= setScan | (scanPendQ & ~{8{outClear}});
      if (scanEnd) begin
        scanOutQ <= scanPendQ;
      end
    end
  end

  // interrupt request is a single pulse per event, never queued
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqReqQ <= '0;
    end else begin
      irqReqQ <= irqFire & ~irqMask;
    end
  end

  // error flags registered so they are glitch free at the port
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfgErrorQ <= '0;
    end else begin
      cfgErrorQ <= cfgErrorD;
    end
  end

  assign resultBit = resultQ;
  assign fastOut   = fastOutQ;
  assign scanOut   = scanOutQ;
  assign relayOut  = relayOutQ;
  assign irqReq    = irqReqQ;
  assign cfgError  = cfgErrorQ;

endmodule // ccs_compare_set

`default_nettype wire

// ===== hw/ccs_pkg.sv
package ccs_pkg;

  // slot pool layout: software slots first, then group A, then group B
  localparam int CNT_W    = 32;
  localparam int NUM_SW   = 6;
  localparam int NUM_GRP  = 4;
  localparam int NUM_SLOT = NUM_SW + 2 * NUM_GRP;
  localparam int NUM_CNT  = 24;
  localparam int NUM_IRQ  = 8;
  localparam int NUM_DIS  = 6;
  localparam int IDX_W    = 3;
  localparam int USE_W    = 5;

  // counter numbers are carried as their plain decimal number
  localparam logic [7:0] CNT_FIRST   = 8'hE8; // 232
  localparam logic [7:0] CNT_HS_FIRST = 8'hEB; // 235
  localparam logic [7:0] CNT_SW_LAST = 8'hF2; // 242
  localparam logic [7:0] CNT_A_MAIN  = 8'hF3; // 243
  localparam logic [7:0] CNT_A_ALIAS = 8'hF5; // 245

  // comparator pool sizes
  localparam logic [USE_W-1:0] POOL_SW = 5'h06;
  localparam logic [USE_W-1:0] POOL_HW = 5'h04;

  // configuration error vector bit positions
  localparam int ERR_SEL     = 0;
  localparam int ERR_IRQMAP  = 1;
  localparam int ERR_SHARE   = 2;
  localparam int ERR_SW_POOL = 3;
  localparam int ERR_HW_POOL = 4;
  localparam int ERR_W       = 5;

  localparam logic [3:0] IRQ_NONE = 4'h8;

  typedef enum logic [1:0] {TGT_FAST, TGT_SCAN, TGT_RELAY, TGT_IRQ}
    ccs_target_t;
  typedef enum logic [1:0] {VAR_SIX_IRQ, VAR_PER_DIS, VAR_SW_HW}
    ccs_variant_t;
  typedef enum logic [1:0] {GRP_NONE, GRP_A, GRP_B} ccs_group_t;

  // interrupt of a counter in the six-interrupt variants
  function automatic logic [3:0] six_irq(input logic [7:0] num);
    unique case (num)
      8'hEB, 8'hF1, 8'hF4, 8'hF6, 8'hF7,
      8'hF9, 8'hFB, 8'hFC, 8'hFE: six_irq = 4'h0;
      8'hEC, 8'hF3:               six_irq = 4'h1;
      8'hED, 8'hF2:               six_irq = 4'h2;
      8'hF5, 8'hEE:               six_irq = 4'h3;
      8'hEF:                      six_irq = 4'h4;
      8'hF0, 8'hFA, 8'hFF:        six_irq = 4'h5;
      default:                    six_irq = IRQ_NONE;
    endcase
  endfunction

  // interrupt of a software counter in the split-comparator variant
  function automatic logic [3:0] sw_irq(input logic [7:0] num);
    unique case (num)
      8'hE8, 8'hEB: sw_irq = 4'h0;
      8'hEC:        sw_irq = 4'h1;
      8'hED:        sw_irq = 4'h2;
      8'hEE:        sw_irq = 4'h3;
      8'hE9, 8'hEF: sw_irq = 4'h4;
      8'hF0:        sw_irq = 4'h5;
      8'hEA, 8'hF1: sw_irq = 4'h6;
      8'hF2:        sw_irq = 4'h7;
      default:      sw_irq = IRQ_NONE;
    endcase
  endfunction

  // hardware group that owns a counter
  function automatic ccs_group_t cnt_group(input logic [7:0] num);
    unique case (num)
      8'hF3, 8'hF5, 8'hF6, 8'hF7,
      8'hF8, 8'hFB, 8'hFC:        cnt_group = GRP_A;
      8'hF4, 8'hF9, 8'hFA,
      8'hFD, 8'hFE:               cnt_group = GRP_B;
      default:                    cnt_group = GRP_NONE;
    endcase
  endfunction

endpackage

// ===== hw/ccs_slot_if.sv
`timescale 1ns/1ps
`default_nettype none

// one comparator slot: selected count in, equality event out
interface ccs_slot_if;
  logic                      en;
  logic                      hwKind;
  logic                      up;
  logic [ccs_pkg::CNT_W-1:0] count;
  logic [ccs_pkg::CNT_W-1:0] value;
  logic                      hit;

  modport cmp (input en, input hwKind, input up, input count,
               input value, output hit);
  modport ctl (output en, output hwKind, output up, output count,
               output value, input hit);
endinterface

`default_nettype wire

// ===== hw/ccs_comparator.sv
`timescale 1ns/1ps
`default_nettype none

module ccs_comparator (
  input wire logic clk_sys,
  input wire logic sys_rst,
  ccs_slot_if.cmp  slot
);

  logic [ccs_pkg::CNT_W-1:0] prevCountQ;
  logic [ccs_pkg::CNT_W-1:0] target;

  // hardware kind fires one step past the value, software on the value
  always_comb begin
    if (slot.hwKind && slot.up) begin
      target = slot.value + 32'h0000_0001;
    end else if (slot.hwKind) begin
      target = slot.value - 32'h0000_0001;
    end else begin
      target = slot.value;
    end
  end

  // last count seen, so only a change of count into the match fires, preset or step
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prevCountQ <= '0;
    end else begin
      prevCountQ <= slot.count;
    end
  end

  // a count parked on the value gives one event, not a stream
  assign slot.hit = slot.en && (slot.count == target)
                    && (slot.count != prevCountQ);

endmodule // ccs_comparator

`default_nettype wire

// ===== tb/ccs_compare_set_props.sv
`timescale 1ns/1ps
`default_nettype none

module ccs_compare_set_props (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire ccs_pkg::ccs_variant_t variant,
  input wire logic [23:0][31:0]     counterValue,
  input wire logic [23:0]           counterUp,
  input wire logic [13:0]           slotEnable,
  input wire logic [13:0][7:0]      slotCounter,
  input wire logic [13:0][31:0]     slotValue,
  input wire logic                  irqDisableAll,
  input wire logic [5:0]            irqDisable,
  input wire logic [13:0]           resultClear,
  input wire logic                  outClear,
  input wire logic                  scanEnd,
  input wire logic [4:0]            swResetUses,
  input wire logic [13:0]           resultBit,
  input wire logic [3:0]            fastOut,
  input wire logic [7:0]            scanOut,
  input wire logic [7:0]            irqReq,
  input wire logic [4:0]            cfgError
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // slot 0 on counter 235 sees a fresh equal count
  sequence swHit;
    slotEnable[0] && slotCounter[0] == ccs_pkg::CNT_HS_FIRST &&
    counterValue[3] == slotValue[0] &&
    counterValue[3] != $past(counterValue[3]);
  endsequence
  // slot 6 on counter 251 counting up reaches value plus one
  sequence hwUpHit;
    variant == ccs_pkg::VAR_SW_HW && slotEnable[6] &&
    slotCounter[6] == 8'hFB && counterUp[19] &&
    counterValue[19] == slotValue[6] + 32'h0000_0001 &&
    counterValue[19] != $past(counterValue[19]);
  endsequence
  // a request while the count sits still, so the next edge must be quiet
  sequence irqThenStill;
    irqReq != 8'h00 && $stable(counterValue);
  endsequence

  sw_fire_a: assert property (swHit |=> resultBit[0])
    else $error("software slot missed its match");
  hw_fire_a: assert property (hwUpHit |=> resultBit[6])
    else $error("hardware slot missed value plus one");
  irq_single_a: assert property (irqThenStill |=> irqReq == 8'h00)
    else $error("interrupt repeated on a still count");
  result_hold_a: assert property (
    ($past(resultBit) & ~$past(resultClear) & ~resultBit) == 14'h0000)
    else $error("result dropped without clear");
  fast_hold_a: assert property (!$past(outClear) |->
    (fastOut & $past(fastOut)) == $past(fastOut))
    else $error("fast output dropped without clear");
  scan_hold_a: assert property (!$past(scanEnd) |-> $stable(scanOut))
    else $error("scan output moved outside scan end");
  mask_all_a: assert property ($past(irqDisableAll) &&
    $past(variant) == ccs_pkg::VAR_SIX_IRQ |-> irqReq == 8'h00)
    else $error("interrupt passed the global disable");
  mask_each_a: assert property ($past(variant) == ccs_pkg::VAR_PER_DIS
    |-> (irqReq[5:0] & $past(irqDisable)) == 6'h00)
    else $error("interrupt passed its own disable");
  bad_sel_a: assert property ($past(slotEnable[0]) &&
    $past(slotCounter[0]) < ccs_pkg::CNT_FIRST |->
    cfgError[ccs_pkg::ERR_SEL])
    else $error("bad selector not flagged");
  sw_pool_a: assert property ($past(slotEnable[0]) &&
    $past(swResetUses) >= ccs_pkg::POOL_SW |->
    cfgError[ccs_pkg::ERR_SW_POOL])
    else $error("software pool overflow not flagged");
endmodule // ccs_compare_set_props

bind ccs_compare_set ccs_compare_set_props i_ccs_compare_set_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .variant(variant),
  .counterValue(counterValue), .counterUp(counterUp),
  .slotEnable(slotEnable), .slotCounter(slotCounter),
  .slotValue(slotValue), .irqDisableAll(irqDisableAll),
  .irqDisable(irqDisable), .resultClear(resultClear),
  .outClear(outClear), .scanEnd(scanEnd), .swResetUses(swResetUses),
  .resultBit(resultBit), .fastOut(fastOut), .scanOut(scanOut),
  .irqReq(irqReq), .cfgError(cfgError)
);

`default_nettype wire

// ===== tb/ccs_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

// pulse sources behind the counters: a preset, then counted steps
module ccs_pulse_src (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              loadEn,
  input  wire logic [31:0]       loadVal,
  input  wire logic              pulse,
  input  wire logic              dirUp,
  input  wire logic [23:0]       holdMask,
  output logic      [23:0][31:0] counterValue,
  output logic      [23:0]       counterUp
);
  // a held counter ignores preset and pulses, so it can sit apart
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      counterValue <= '0;
      counterUp    <= '0;
    end else begin
      counterUp <= {24{dirUp}};
      for (int i = 0; i < 24; i++) begin
        if (!holdMask[i] && loadEn) begin
          counterValue[i] <= loadVal;
        end else if (!holdMask[i] && pulse) begin
          counterValue[i] <= dirUp ? counterValue[i] + 32'h0000_0001
                                   : counterValue[i] - 32'h0000_0001;
        end
      end
    end
  end
endmodule // ccs_pulse_src

`default_nettype wire

// ===== tb/ccs_compare_set_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module ccs_compare_set_tb_top;
  logic                        clk_sys = 1'b0, sys_rst = 1'b1;
  ccs_pkg::ccs_variant_t       variant = ccs_pkg::VAR_SIX_IRQ;
  ccs_pkg::ccs_target_t [13:0] slotTarget = {14{ccs_pkg::TGT_FAST}};
  logic [23:0][31:0]           counterValue;
  logic [23:0]                 counterUp, holdMask = '0, otherUseMask = '0;
  logic [13:0]                 slotEnable = '0, resultClear = '0, resultBit;
  logic [13:0][7:0]            slotCounter = '0;
  logic [13:0][31:0]           slotValue = '0;
  logic [13:0][2:0]            slotIndex = '0;
  logic [4:0]                  swResetUses = '0, grpAResetUses = '0;
  logic [4:0]                  grpBResetUses = '0, cfgError;
  logic [5:0]                  irqDisable = '0;
  logic                        grpAMainOn = 1'b0, irqDisableAll = 1'b0;
  logic                        loadEn = 1'b0, pulse = 1'b0, dirUp = 1'b0;
  logic                        outClear = 1'b0, scanEnd = 1'b0;
  logic [3:0]                  fastOut, k;
  logic [7:0]                  scanOut, relayOut, irqReq;
  logic [31:0]                 v, r, loadVal = '0;
  int                          seed = 54, failCount = 0;
  int                          samplesChecked = 0, cycles = 0;

  ccs_pulse_src i_ccs_pulse_src (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .loadEn(loadEn),
    .loadVal(loadVal), .pulse(pulse), .dirUp(dirUp), .holdMask(holdMask),
    .counterValue(counterValue), .counterUp(counterUp));
  ccs_compare_set i_ccs_compare_set (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .variant(variant),
    .counterValue(counterValue), .counterUp(counterUp),
    .grpAMainOn(grpAMainOn), .slotEnable(slotEnable),
    .slotCounter(slotCounter), .slotValue(slotValue),
    .slotTarget(slotTarget), .slotIndex(slotIndex),
    .otherUseMask(otherUseMask), .swResetUses(swResetUses),
    .grpAResetUses(grpAResetUses), .grpBResetUses(grpBResetUses),
    .irqDisableAll(irqDisableAll), .irqDisable(irqDisable),
    .resultClear(resultClear), .outClear(outClear), .scanEnd(scanEnd),
    .resultBit(resultBit), .fastOut(fastOut), .scanOut(scanOut),
    .relayOut(relayOut), .irqReq(irqReq), .cfgError(cfgError));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      endOfTest();
    end
  end

  task automatic endOfTest();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // interrupt of a counter: software split map or six-interrupt map
  function automatic logic [3:0] expIrq(input logic sw, input logic [7:0] n);
    if (sw) begin
      case (n)
        8'hE8, 8'hEB: expIrq = 4'h0;
        8'hEC: expIrq = 4'h1;
        8'hED: expIrq = 4'h2;
        8'hEE: expIrq = 4'h3;
        8'hE9, 8'hEF: expIrq = 4'h4;
        8'hF0: expIrq = 4'h5;
        8'hEA, 8'hF1: expIrq = 4'h6;
        8'hF2: expIrq = 4'h7;
        default: expIrq = 4'h8;
      endcase
    end else begin
      case (n)
        8'hEB, 8'hF1, 8'hF4, 8'hF6, 8'hF7, 8'hF9, 8'hFB, 8'hFC,
        8'hFE: expIrq = 4'h0;
        8'hEC, 8'hF3: expIrq = 4'h1;
        8'hED, 8'hF2: expIrq = 4'h2;
        8'hF5, 8'hEE: expIrq = 4'h3;
        8'hEF: expIrq = 4'h4;
        8'hF0, 8'hFA, 8'hFF: expIrq = 4'h5;
        default: expIrq = 4'h8;
      endcase
    end
  endfunction

  // counted steps; returns just after the edge that shows the result
  task automatic steps(input int n);
    @(posedge clk_sys);
    loadEn <= 1'b0;
    resultClear <= '0;
    outClear <= 1'b0;
    pulse <= 1'b1;
    repeat (n) @(posedge clk_sys);
    pulse <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // one slot alone, counters preset one short of a random value, one step
  task automatic go(input int s, input logic [7:0] n,
                    input ccs_pkg::ccs_target_t t, input logic [2:0] ix,
                    input logic up);
    @(posedge clk_sys);
    v = $random(seed) & 32'h00FF_FF00 | 32'h0000_0100;
    slotEnable <= 14'h0001 << s;
    slotCounter[s] <= n;
    slotValue[s] <= v;
    slotTarget[s] <= t;
    slotIndex[s] <= ix;
    loadVal <= up ? v - 32'h1 : v + 32'h1;
    dirUp <= up;
    loadEn <= 1'b1;
    resultClear <= '1;
    outClear <= 1'b1;
    steps(1);
  endtask

  task automatic mask(input ccs_pkg::ccs_variant_t vr, input logic all,
                      input logic [5:0] dis, input logic [7:0] e);
    @(posedge clk_sys);
    variant <= vr;
    irqDisableAll <= all;
    irqDisable <= dis;
    go(0, 8'hEB, ccs_pkg::TGT_IRQ, 3'h0, 1'b1);
    chk("irqMask", irqReq, e);
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // every counter of both interrupt maps, then a step away from the match
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      variant <= m ? ccs_pkg::VAR_SW_HW : ccs_pkg::VAR_SIX_IRQ;
      for (int n = 232; n < 256; n++) begin
        k = expIrq(m[0], n[7:0]);
        if (k != 4'h8) begin
          go(0, n[7:0], ccs_pkg::TGT_IRQ, k[2:0], 1'b1);
          chk("irqReq", irqReq, 8'h01 << k);
          chk("mapErr", cfgError[1], 1'b0);
          steps(1);
          chk("irqAgain", irqReq, 8'h00);
          chk("sticky", resultBit[0], 1'b1);
        end
      end
    end
    go(0, 8'hEB, ccs_pkg::TGT_FAST, 3'h2, 1'b0);
    chk("fastOut", fastOut, 4'h4);
    go(0, 8'hEC, ccs_pkg::TGT_SCAN, 3'h5, 1'b1);
    chk("scanEarly", scanOut, 8'h00);
    @(posedge clk_sys);
    scanEnd <= 1'b1;
    @(posedge clk_sys);
    scanEnd <= 1'b0;
    #1;
    chk("scanOut", scanOut, 8'h20);
    go(0, 8'hED, ccs_pkg::TGT_RELAY, 3'h3, 1'b1);
    chk("relayOut", relayOut, 8'h08);
    mask(ccs_pkg::VAR_SIX_IRQ, 1'b1, 6'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      mask(ccs_pkg::VAR_PER_DIS, 1'b0, r[5:0], {7'h00, ~r[0]});
    end
    @(posedge clk_sys);
    variant <= ccs_pkg::VAR_SW_HW;
    // hardware slots of both groups, counted up and down
    for (int i = 0; i < 4; i++) begin
      go(i < 2 ? 6 : 10, i < 2 ? 8'hFB : 8'hFA, ccs_pkg::TGT_RELAY,
         3'h1, i[0]);
      chk("hwEarly", resultBit, 14'h0000);
      steps(1);
      chk("hwFire", resultBit, 14'h0040 << (i / 2 * 4));
    end
    for (int i = 0; i < 2; i++) begin
      go(6, 8'hFB, ccs_pkg::TGT_IRQ, i[0] ? 3'h4 : 3'h0, 1'b1);
      chk("grpIrq", cfgError[1], i[0]);
    end
    // counter 245 held still: only counter 243 can make it fire
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      grpAMainOn <= i[0];
      holdMask <= 24'h00_2000;
      go(6, 8'hF5, ccs_pkg::TGT_RELAY, 3'h0, 1'b1);
      steps(1);
      chk("alias", resultBit[6], i[0]);
      chk("aliasErr", cfgError[0], 1'b0);
    end
    // pools at their limit, then one past it, with a shared counter
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      holdMask <= '0;
      swResetUses <= i ? 5'h06 : 5'h05;
      grpAResetUses <= i ? 5'h05 : 5'h04;
      otherUseMask <= i ? 24'h00_0008 : 24'h00_0000;
      go(0, 8'hEB, ccs_pkg::TGT_IRQ, 3'h0, 1'b1);
      chk("poolErr", cfgError[4:2], {3{i[0]}});
    end
    go(0, 8'h10, ccs_pkg::TGT_RELAY, 3'h0, 1'b1);
    chk("selErr", cfgError[0], 1'b1);
    endOfTest();
  end
endmodule // ccs_compare_set_tb_top

`default_nettype wire
